// file: rtl/drive_param_scaling_backup.sv
// Drive end: parameter store, flash backup, scaling selection and position scaling
`timescale 1ns/1ps
`include "scaling_params.svh"
module drive_param_scaling_backup
  import scaling_pkg::*;
#(
  parameter int unsigned BACKUP_CYCLES = `BACKUP_CYCLES,
  parameter int unsigned NWORDS = 7
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic porRst,
  input wire logic ce,
  param_link_if.drive link,
  input wire logic [31:0] motorPos,
  output logic [31:0] busPosQ,
  output logic scaleActiveQ,
  output logic loadRefQ,
  output logic moduloQ,
  output logic [15:0] posFactorQ,
  output logic [15:0] posExpQ,
  output logic [31:0] gearInQ,
  output logic [31:0] gearOutQ,
  output logic backupBusyQ,
  output logic flashValidQ
);
  if (NWORDS != 7) $error("NWORDS must be 7");
  if (BACKUP_CYCLES < 1) $error("BACKUP_CYCLES must be at least 1");

  localparam logic [31:0] WAIT_LAST = 32'(BACKUP_CYCLES - 1);

  function automatic logic [2:0] idxOf(input ident_t id);
    unique case (id)
      `ID_POS_TYPE: idxOf = `IDX_TYPE;
      `ID_POS_FACTOR: idxOf = `IDX_FACTOR;
      `ID_POS_EXP: idxOf = `IDX_EXP;
      `ID_ROT_RES: idxOf = `IDX_RES;
      `ID_GEAR_IN: idxOf = `IDX_GEAR_IN;
      `ID_GEAR_OUT: idxOf = `IDX_GEAR_OUT;
      `ID_FEED: idxOf = `IDX_FEED;
      default: idxOf = `IDX_NONE;
    endcase
  endfunction

  // Factory values when nothing was ever saved
  function automatic word_t defVal(input logic [2:0] i);
    unique case (i)
      `IDX_TYPE: defVal = `DEF_TYPE;
      `IDX_FACTOR: defVal = `DEF_FACTOR;
      `IDX_EXP: defVal = `DEF_EXP;
      `IDX_RES: defVal = `DEF_RES;
      `IDX_FEED: defVal = `DEF_FEED;
      default: defVal = `DEF_GEAR;
    endcase
  endfunction

  // Fixed LSB weights, read back as signed decimal exponents
  function automatic logic [32:0] weightOf(input ident_t id);
    unique case (id)
      `ID_W_POSITION: weightOf = {1'b1, `EXP_POSITION};
      `ID_W_SPEED: weightOf = {1'b1, `EXP_SPEED};
      `ID_W_ACCEL: weightOf = {1'b1, `EXP_ACCEL};
      `ID_W_TORQUE: weightOf = {1'b1, `EXP_TORQUE};
      `ID_W_TEMP: weightOf = {1'b1, `EXP_TEMP};
      `ID_W_CURRENT: weightOf = {1'b1, `EXP_CURRENT};
      `ID_W_VOLTAGE: weightOf = {1'b1, `EXP_VOLTAGE};
      `ID_W_TIME_MS: weightOf = {1'b1, `EXP_TIME_MS};
      `ID_W_TIME_US: weightOf = {1'b1, `EXP_TIME_US};
      `ID_W_PERCENT: weightOf = {1'b1, `EXP_PERCENT};
      default: weightOf = 33'h000000000;
    endcase
  endfunction

  function automatic logic typeLegal(input word_t v);
    logic [2:0] meth;
    meth = v[`TYPE_METH_MSB:`TYPE_METH_LSB];
    typeLegal = 1'b1;
    if (meth != `METH_LINEAR && meth != `METH_ROT) typeLegal = 1'b0;
    if (v[`TYPE_PREF_BIT] || v[`TYPE_UNIT_BIT]) typeLegal = 1'b0;
    if (meth == `METH_LINEAR && !v[`TYPE_REF_BIT]) typeLegal = 1'b0;
    if (v[31:16] != 16'h0000) typeLegal = 1'b0;
  endfunction

  backup_state_t bkStQ;
  logic [2:0] cpyQ;
  logic [31:0] bkCntQ;
  logic chkDoneQ;
  word_t wrkQ [NWORDS];
  word_t actQ [NWORDS];
  word_t flashQ [NWORDS];

  logic [2:0] idx;
  logic paramPhase;
  logic wrParam;
  logic bkStart;
  logic bkClear;
  logic chkStart;
  logic chkClear;
  logic reqErr;
  word_t wrWord;
  word_t rdWord;
  logic [32:0] weight;
  logic [63:0] prod;

  always_comb
  begin
    idx = idxOf(link.ident);
    weight = weightOf(link.ident);
    paramPhase = link.phase == `PHASE_PARAM || link.phase == `PHASE_CHECK;
    // Narrow fields: factor unsigned 16 bit, exponent signed 16 bit
    wrWord = link.wrData;
    if (idx == `IDX_FACTOR) wrWord = {16'h0000, link.wrData[15:0]};
    if (idx == `IDX_EXP) wrWord = {{16{link.wrData[15]}}, link.wrData[15:0]};
    wrParam = link.reqValid && link.reqWrite && idx != `IDX_NONE && paramPhase
      && bkStQ != BK_COPY && bkStQ != BK_WAIT
      && (idx != `IDX_TYPE || typeLegal(link.wrData))
      && (idx < `IDX_GEAR_IN || link.wrData != 32'h00000000);
    bkStart = link.reqValid && link.reqWrite && link.ident == `ID_BACKUP
      && link.wrData == `CMD_START && bkStQ == BK_IDLE
      && (paramPhase || link.phase == `PHASE_OP);
    bkClear = link.reqValid && link.reqWrite && link.ident == `ID_BACKUP
      && link.wrData == `CMD_CLEAR && bkStQ != BK_COPY && bkStQ != BK_WAIT;
    chkStart = link.reqValid && link.reqWrite && link.ident == `ID_CHECK
      && link.wrData == `CMD_START && link.phase == `PHASE_CHECK;
    chkClear = link.reqValid && link.reqWrite && link.ident == `ID_CHECK
      && link.wrData == `CMD_CLEAR;
    rdWord = 32'h00000000;
    reqErr = 1'b0;
    if (link.reqWrite)
      reqErr = !(wrParam || bkStart || bkClear || chkStart || chkClear);
    else if (idx != `IDX_NONE)
      rdWord = wrkQ[idx];
    else if (link.ident == `ID_BACKUP)
    begin
      rdWord[`CMD_DONE_BIT] = bkStQ == BK_DONE;
      rdWord[`CMD_BUSY_BIT] = bkStQ == BK_COPY || bkStQ == BK_WAIT;
    end
    else if (link.ident == `ID_CHECK)
      rdWord[`CMD_DONE_BIT] = chkDoneQ;
    else if (weight[32])
      rdWord = weight[31:0];
    else
      reqErr = 1'b1;
  end

  // Working set: restored from flash on the drive reset rst, factory values on porRst or without a valid flash image
  always_ff @(posedge mclk)
  begin
    if (rst || porRst)
    begin
      for (int i = 0; i < NWORDS; i++)
        wrkQ[i] <= (flashValidQ && !porRst) ? flashQ[i] : defVal(3'(i));
    end
    else if (ce && wrParam)
      wrkQ[idx] <= wrWord;
  end

  // Active set only follows the working set at the phase-3 transition check
  always_ff @(posedge mclk)
  begin
    if (rst || porRst)
    begin
      for (int i = 0; i < NWORDS; i++)
        actQ[i] <= (flashValidQ && !porRst) ? flashQ[i] : defVal(3'(i));
      chkDoneQ <= 1'b0;
    end
    else if (ce)
    begin
      if (chkStart)
      begin
        for (int i = 0; i < NWORDS; i++)
          actQ[i] <= wrkQ[i];
        chkDoneQ <= 1'b1;
      end
      else if (chkClear)
        chkDoneQ <= 1'b0;
    end
  end

  // Backup sequencer: word copy, then the flash programming time
  always_ff @(posedge mclk)
  begin
    if (rst || porRst)
    begin
      bkStQ <= BK_IDLE;
      cpyQ <= 3'h0;
      bkCntQ <= 32'h00000000;
    end
    else if (ce)
    begin
      unique case (bkStQ)
        BK_IDLE:
        begin
          cpyQ <= 3'h0;
          if (bkStart) bkStQ <= BK_COPY;
        end
        BK_COPY:
        begin
          cpyQ <= cpyQ + 3'h1;
          bkCntQ <= 32'h00000000;
          if (cpyQ == 3'(NWORDS - 1)) bkStQ <= BK_WAIT;
        end
        BK_WAIT:
        begin
          bkCntQ <= bkCntQ + 32'h00000001;
          if (bkCntQ == WAIT_LAST) bkStQ <= BK_DONE;
        end
        BK_DONE:
          if (bkClear) bkStQ <= BK_IDLE;
      endcase
    end
  end

  // Flash image survives the drive reset; only power-on clears its valid mark
  always_ff @(posedge mclk)
  begin
    if (porRst)
      flashValidQ <= 1'b0;
    else if (ce && bkStQ == BK_COPY)
    begin
      flashQ[cpyQ] <= wrkQ[cpyQ];
      if (cpyQ == 3'(NWORDS - 1)) flashValidQ <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || porRst)
    begin
      link.rspValid <= 1'b0;
      link.rspErr <= 1'b0;
      link.rdData <= 32'h00000000;
    end
    else if (ce)
    begin
      link.rspValid <= link.reqValid;
      link.rspErr <= link.reqValid && reqErr;
      link.rdData <= link.reqValid ? rdWord : 32'h00000000;
    end
  end

  // Internal position carries 2^32 increments per turn; bus value is 32 bits
  always_comb
  begin
    if (actQ[`IDX_TYPE][`TYPE_METH_MSB:`TYPE_METH_LSB] == `METH_LINEAR)
      prod = {32'h00000000, motorPos} * {32'h00000000, actQ[`IDX_FEED]};
    else
      prod = {32'h00000000, motorPos} * {32'h00000000, actQ[`IDX_RES]};
  end

  always_ff @(posedge mclk)
  begin
    if (rst || porRst)
    begin
      busPosQ <= 32'h00000000;
      scaleActiveQ <= 1'b0;
      loadRefQ <= 1'b0;
      moduloQ <= 1'b0;
      posFactorQ <= 16'h0000;
      posExpQ <= 16'h0000;
      gearInQ <= 32'h00000000;
      gearOutQ <= 32'h00000000;
      backupBusyQ <= 1'b0;
    end
    else if (ce)
    begin
      scaleActiveQ <= link.phase == `PHASE_OP;
      busPosQ <= link.phase == `PHASE_OP ? prod[63:32] : motorPos;
      loadRefQ <= actQ[`IDX_TYPE][`TYPE_REF_BIT];
      moduloQ <= actQ[`IDX_TYPE][`TYPE_MOD_BIT];
      posFactorQ <= actQ[`IDX_FACTOR][15:0];
      posExpQ <= actQ[`IDX_EXP][15:0];
      gearInQ <= actQ[`IDX_GEAR_IN];
      gearOutQ <= actQ[`IDX_GEAR_OUT];
      backupBusyQ <= bkStQ == BK_COPY || bkStQ == BK_WAIT;
    end
  end
endmodule

// file: rtl/scaling_params.svh
// Shared constants for the parameter backup and position scaling link
`ifndef SCALING_PARAMS_SVH
`define SCALING_PARAMS_SVH

`define ID_BACKUP 16'h0108
`define ID_CHECK 16'h0080
`define ID_POS_TYPE 16'h004c
`define ID_POS_FACTOR 16'h004d
`define ID_POS_EXP 16'h004e
`define ID_ROT_RES 16'h004f
`define ID_GEAR_IN 16'h0079
`define ID_GEAR_OUT 16'h007a
`define ID_FEED 16'h007b
`define ID_W_SPEED 16'h7f00
`define ID_W_ACCEL 16'h7f01
`define ID_W_TORQUE 16'h7f02
`define ID_W_TEMP 16'h7f03
`define ID_W_CURRENT 16'h7f04
`define ID_W_VOLTAGE 16'h7f05
`define ID_W_TIME_MS 16'h7f06
`define ID_W_TIME_US 16'h7f07
`define ID_W_PERCENT 16'h7f08
`define ID_W_POSITION 16'h7f09

`define IDX_TYPE 3'h0
`define IDX_FACTOR 3'h1
`define IDX_EXP 3'h2
`define IDX_RES 3'h3
`define IDX_GEAR_IN 3'h4
`define IDX_GEAR_OUT 3'h5
`define IDX_FEED 3'h6
`define IDX_NONE 3'h7

`define TYPE_METH_LSB 0
`define TYPE_METH_MSB 2
`define TYPE_PREF_BIT 3
`define TYPE_UNIT_BIT 4
`define TYPE_REF_BIT 6
`define TYPE_MOD_BIT 7
`define METH_NONE 3'h0
`define METH_LINEAR 3'h1
`define METH_ROT 3'h2

`define DEF_TYPE 32'h00000002
`define DEF_FACTOR 32'h00000001
`define DEF_EXP 32'hfffffff9
`define DEF_RES 32'h0036ee80
`define DEF_GEAR 32'h00000001
`define DEF_FEED 32'h00001388

`define EXP_POSITION 32'hfffffffc
`define EXP_SPEED 32'hfffffffc
`define EXP_ACCEL 32'hfffffffd
`define EXP_TORQUE 32'hfffffffe
`define EXP_TEMP 32'hffffffff
`define EXP_CURRENT 32'hfffffffd
`define EXP_VOLTAGE 32'hfffffffd
`define EXP_TIME_MS 32'hfffffffc
`define EXP_TIME_US 32'hfffffffa
`define EXP_PERCENT 32'hfffffffe

`define PHASE_PARAM 3'h2
`define PHASE_CHECK 3'h3
`define PHASE_OP 3'h4

`define CMD_START 32'h00000003
`define CMD_CLEAR 32'h00000000
`define CMD_DONE_BIT 8
`define CMD_BUSY_BIT 9

`define CLK_MHZ 100
`define BACKUP_TIME_MS 2000
`define BACKUP_CYCLES (`BACKUP_TIME_MS * 1000 * `CLK_MHZ)

`endif

// file: rtl/scaling_pkg.sv
// Types shared by both ends of the parameter link
package scaling_pkg;
  typedef logic [15:0] ident_t;
  typedef logic [31:0] word_t;
  typedef logic [2:0] phase_t;
  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_COPY = 2'b01,
    BK_WAIT = 2'b10,
    BK_DONE = 2'b11
  } backup_state_t;
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_SEND = 3'b001,
    MS_WAIT = 3'b010,
    MS_POLL = 3'b011,
    MS_CLEAR = 3'b100,
    MS_FIN = 3'b101
  } master_state_t;
  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_BACKUP = 2'b10,
    OP_CHECK = 2'b11
  } op_kind_t;
endpackage

// file: rtl/param_link_if.sv
// Service-channel style link between master and drive
`timescale 1ns/1ps
interface param_link_if;
  import scaling_pkg::*;
  phase_t phase;
  logic reqValid;
  logic reqWrite;
  ident_t ident;
  word_t wrData;
  logic rspValid;
  logic rspErr;
  word_t rdData;
  modport drive (
    input phase,
    input reqValid,
    input reqWrite,
    input ident,
    input wrData,
    output rspValid,
    output rspErr,
    output rdData
  );
  modport master (
    output phase,
    output reqValid,
    output reqWrite,
    output ident,
    output wrData,
    input rspValid,
    input rspErr,
    input rdData
  );
endinterface

// file: rtl/param_link_master.sv
// Master end: runs reads, writes and procedure commands over the link
`timescale 1ns/1ps
`include "scaling_params.svh"
module param_link_master
  import scaling_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  param_link_if.master link,
  input wire logic [2:0] phaseReq,
  input wire logic opValid,
  input wire logic [1:0] opKind,
  input wire logic [15:0] opIdent,
  input wire logic [31:0] opData,
  output logic opBusyQ,
  output logic opDoneQ,
  output logic opErrQ,
  output logic [31:0] opRdDataQ
);
  master_state_t stQ;
  logic isCmdQ;
  ident_t idQ;
  word_t dataQ;
  logic writeQ;

  always_ff @(posedge mclk)
  begin
    if (rst)
      link.phase <= 3'h0;
    else if (ce)
      link.phase <= phaseReq;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stQ <= MS_IDLE;
      isCmdQ <= 1'b0;
      idQ <= 16'h0000;
      dataQ <= 32'h00000000;
      writeQ <= 1'b0;
      link.reqValid <= 1'b0;
      link.reqWrite <= 1'b0;
      link.ident <= 16'h0000;
      link.wrData <= 32'h00000000;
      opBusyQ <= 1'b0;
      opDoneQ <= 1'b0;
      opErrQ <= 1'b0;
      opRdDataQ <= 32'h00000000;
    end
    else if (ce)
    begin
      link.reqValid <= 1'b0;
      opDoneQ <= 1'b0;
      unique case (stQ)
        MS_IDLE:
          if (opValid)
          begin
            opBusyQ <= 1'b1;
            opErrQ <= 1'b0;
            isCmdQ <= opKind == OP_BACKUP || opKind == OP_CHECK;
            writeQ <= opKind != OP_READ;
            unique case (opKind)
              OP_BACKUP: idQ <= `ID_BACKUP;
              OP_CHECK: idQ <= `ID_CHECK;
              default: idQ <= opIdent;
            endcase
            // Commands are started with the start code; data stay integers
            dataQ <= (opKind == OP_BACKUP || opKind == OP_CHECK) ? `CMD_START : opData;
            stQ <= MS_SEND;
          end
        MS_SEND:
        begin
          link.reqValid <= 1'b1;
          link.reqWrite <= writeQ;
          link.ident <= idQ;
          link.wrData <= dataQ;
          stQ <= MS_WAIT;
        end
        MS_WAIT:
          if (link.rspValid)
          begin
            opRdDataQ <= link.rdData;
            if (link.rspErr)
            begin
              opErrQ <= 1'b1;
              stQ <= MS_FIN;
            end
            else if (isCmdQ && writeQ && dataQ == `CMD_START)
              stQ <= MS_POLL;
            else if (isCmdQ && !writeQ && !link.rdData[`CMD_DONE_BIT])
              stQ <= MS_POLL;
            else if (isCmdQ && !writeQ)
              stQ <= MS_CLEAR;
            else
              stQ <= MS_FIN;
          end
        MS_POLL:
        begin
          writeQ <= 1'b0;
          stQ <= MS_SEND;
        end
        MS_CLEAR:
        begin
          writeQ <= 1'b1;
          dataQ <= `CMD_CLEAR;
          stQ <= MS_SEND;
        end
        MS_FIN:
        begin
          opBusyQ <= 1'b0;
          opDoneQ <= 1'b1;
          stQ <= MS_IDLE;
        end
        default:
          stQ <= MS_IDLE;
      endcase
    end
  end
endmodule

// file: test/scaling_link_sva.sv
// Concurrent checks on the parameter link between master and drive
`timescale 1ns/1ps
`include "scaling_params.svh"
module scaling_link_sva
  import scaling_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire phase_t phase,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire ident_t ident,
  input wire word_t wrData,
  input wire logic rspValid,
  input wire logic rspErr,
  input wire word_t rdData
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Write of the position scaling type
  sequence typeWr;
    reqValid && reqWrite && ident == `ID_POS_TYPE;
  endsequence

  // Refusal answer in the following cycle
  sequence errNext;
    ##1 (rspValid && rspErr);
  endsequence

  a_answer_next: assert property (reqValid |=> rspValid)
    else $error("no answer in the cycle after a request");
  a_answer_caused: assert property (rspValid |-> $past(reqValid))
    else $error("answer without a request");
  a_idle_data_zero: assert property (!rspValid |-> (rdData == 32'h0 && !rspErr))
    else $error("answer lines not zero between answers");
  a_type_phase_err: assert property (
    typeWr ##0 (phase != `PHASE_PARAM && phase != `PHASE_CHECK) |-> errNext)
    else $error("type write outside phases 2 and 3 accepted");
  a_type_method_err: assert property (
    typeWr ##0 (wrData[2:0] != `METH_LINEAR && wrData[2:0] != `METH_ROT) |-> errNext)
    else $error("type write with illegal method accepted");
  a_type_unit_err: assert property (typeWr ##0 (wrData[3] || wrData[4]) |-> errNext)
    else $error("type write with bit 3 or 4 set accepted");
  a_linear_motor_err: assert property (
    typeWr ##0 (wrData[2:0] == `METH_LINEAR && !wrData[6]) |-> errNext)
    else $error("linear scaling at the motor shaft accepted");
  a_pos_weight: assert property (
    reqValid && !reqWrite && ident == `ID_W_POSITION
    |=> rspValid && !rspErr && rdData == 32'hfffffffc)
    else $error("position weight read wrong");
  a_check_phase_err: assert property (
    reqValid && reqWrite && ident == `ID_CHECK && wrData == `CMD_START
    && phase != `PHASE_CHECK |=> rspErr)
    else $error("transition check started outside phase 3");
endmodule

// file: test/tb_top.sv
// Testbench joining the master and drive ends over the parameter link
`timescale 1ns/1ps
`include "scaling_params.svh"
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errCount++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb_top;
  import scaling_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic porRst = 1'b1;
  logic [2:0] phaseReq = 3'h0;
  logic opValid = 1'b0;
  logic [1:0] opKind = 2'h0;
  logic [15:0] opIdent = 16'h0;
  logic [31:0] opData = 32'h0;
  logic [31:0] motorPos = 32'h0;
  logic ce = 1'b1;
  logic opBusyQ;
  logic [31:0] busPosQ, gearInQ, gearOutQ, opRdDataQ, rd;
  logic [15:0] posFactorQ, posExpQ;
  logic scaleActiveQ, loadRefQ, moduloQ, backupBusyQ, flashValidQ, opDoneQ, opErrQ, err;
  int errCount = 0;
  int comparisons = 0;
  int lastN = 0;
  param_link_if link();
  always #5 mclk = ~mclk;
  drive_param_scaling_backup #(.BACKUP_CYCLES(5)) drive_param_scaling_backup_inst (
    .mclk(mclk), .rst(rst), .porRst(porRst), .ce(ce), .link(link), .motorPos(motorPos),
    .busPosQ(busPosQ), .scaleActiveQ(scaleActiveQ), .loadRefQ(loadRefQ), .moduloQ(moduloQ),
    .posFactorQ(posFactorQ), .posExpQ(posExpQ), .gearInQ(gearInQ), .gearOutQ(gearOutQ),
    .backupBusyQ(backupBusyQ), .flashValidQ(flashValidQ));
  param_link_master param_link_master_inst (
    .mclk(mclk), .rst(rst), .ce(ce), .link(link), .phaseReq(phaseReq), .opValid(opValid),
    .opKind(opKind), .opIdent(opIdent), .opData(opData), .opBusyQ(opBusyQ), .opDoneQ(opDoneQ),
    .opErrQ(opErrQ), .opRdDataQ(opRdDataQ));
  scaling_link_sva scaling_link_sva_inst (
    .mclk(mclk), .rst(rst), .phase(link.phase), .reqValid(link.reqValid),
    .reqWrite(link.reqWrite), .ident(link.ident), .wrData(link.wrData),
    .rspValid(link.rspValid), .rspErr(link.rspErr), .rdData(link.rdData));

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic doReset(input logic por);
    rst = 1'b1;
    porRst = por;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    porRst = 1'b0;
    @(negedge mclk);
  endtask

  task automatic setPhase(input logic [2:0] p);
    phaseReq = p;
    repeat (3) @(negedge mclk);
  endtask

  // One master operation, waiting for its done pulse under a bound
  task automatic op(input logic [1:0] k, input logic [15:0] id, input logic [31:0] d);
    opKind = k;
    opIdent = id;
    opData = d;
    opValid = 1'b1;
    @(negedge mclk);
    opValid = 1'b0;
    `CHK("op busy", 1'b1, opBusyQ)
    lastN = 0;
    while (opDoneQ !== 1'b1 && lastN < 3000)
    begin
      @(negedge mclk);
      lastN++;
    end
    if (lastN >= 3000)
    begin
      errCount++;
      $display("CHECK FAILED op done expected 1 seen 0");
    end
    `CHK("op idle", 1'b0, opBusyQ)
    err = opErrQ;
    rd = opRdDataQ;
    @(negedge mclk);
  endtask

  task automatic t_defaults;
    int w [10] = '{-4, -3, -2, -1, -3, -3, -4, -6, -2, -4};
    setPhase(`PHASE_PARAM);
    for (int i = 0; i < 10; i++)
    begin
      op(OP_READ, 16'h7f00 + 16'(i), 32'h0);
      `CHK("weight", 32'(w[i]), rd)
    end
    op(OP_READ, `ID_POS_TYPE, 32'h0);
    `CHK("default type", 32'h00000002, rd)
    op(OP_READ, `ID_ROT_RES, 32'h0);
    `CHK("resolution", 32'h0036ee80, rd)
    `CHK("factor", 16'h0001, posFactorQ)
    `CHK("exponent", 16'hfff9, posExpQ)
    `CHK("gear in", 32'h1, gearInQ)
    `CHK("gear out", 32'h1, gearOutQ)
    op(OP_WRITE, `ID_W_TORQUE, 32'h1);
    `CHK("weight write", 1'b1, err)
    motorPos = 32'h12345678;
    repeat (2) @(negedge mclk);
    `CHK("unscaled position", 32'h12345678, busPosQ)
    $display("test defaults done");
  endtask

  task automatic t_type;
    logic [15:0] bad [5] = '{16'h0000, 16'h0001, 16'h000a, 16'h0012, 16'h0003};
    foreach (bad[i])
    begin
      op(OP_WRITE, `ID_POS_TYPE, {16'h0, bad[i]});
      `CHK("bad type", 1'b1, err)
    end
    op(OP_READ, `ID_POS_TYPE, 32'h0);
    `CHK("type kept", 32'h00000002, rd)
    op(OP_WRITE, `ID_FEED, 32'h0);
    `CHK("zero feed", 1'b1, err)
    $display("test type done");
  endtask

  task automatic t_apply;
    op(OP_WRITE, `ID_POS_TYPE, 32'h000000c2);
    `CHK("rot load modulo", 1'b0, err)
    `CHK("not yet active", 1'b0, loadRefQ)
    setPhase(`PHASE_CHECK);
    op(OP_CHECK, `ID_CHECK, `CMD_START);
    `CHK("check", 1'b0, err)
    `CHK("load ref", 1'b1, loadRefQ)
    `CHK("modulo", 1'b1, moduloQ)
    setPhase(`PHASE_OP);
    motorPos = 32'h80000000;
    repeat (2) @(negedge mclk);
    `CHK("scaling active", 1'b1, scaleActiveQ)
    `CHK("rot position", 32'h001b7740, busPosQ)
    op(OP_WRITE, `ID_POS_TYPE, 32'h00000041);
    `CHK("write in phase 4", 1'b1, err)
    op(OP_CHECK, `ID_CHECK, `CMD_START);
    `CHK("check in phase 4", 1'b1, err)
    setPhase(`PHASE_PARAM);
    op(OP_WRITE, `ID_POS_TYPE, 32'h00000041);
    `CHK("linear load", 1'b0, err)
    op(OP_WRITE, `ID_FEED, 32'h000003e8);
    `CHK("feed", 1'b0, err)
    op(OP_WRITE, `ID_POS_EXP, 32'h1234fffa);
    op(OP_READ, `ID_POS_EXP, 32'h0);
    `CHK("exponent sign", 32'hfffffffa, rd)
    op(OP_WRITE, `ID_GEAR_IN, 32'h00000003);
    `CHK("gear write", 1'b0, err)
    setPhase(`PHASE_CHECK);
    op(OP_CHECK, `ID_CHECK, `CMD_START);
    `CHK("active exponent", 16'hfffa, posExpQ)
    `CHK("active gear", 32'h00000003, gearInQ)
    setPhase(`PHASE_OP);
    motorPos = 32'h40000000;
    repeat (2) @(negedge mclk);
    `CHK("lin position", 32'h000000fa, busPosQ)
    `CHK("absolute", 1'b0, moduloQ)
    // Clock enable low must freeze the scaled position
    ce = 1'b0;
    motorPos = 32'h80000000;
    repeat (3) @(negedge mclk);
    `CHK("frozen position", 32'h000000fa, busPosQ)
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("thawed position", 32'h000001f4, busPosQ)
    $display("test apply done");
  endtask

  task automatic t_backup;
    setPhase(`PHASE_PARAM);
    op(OP_BACKUP, `ID_BACKUP, `CMD_START);
    `CHK("backup", 1'b0, err)
    `CHK("backup length", 1'b1, lastN >= 12)
    `CHK("flash valid", 1'b1, flashValidQ)
    `CHK("backup idle", 1'b0, backupBusyQ)
    op(OP_WRITE, `ID_POS_TYPE, 32'h00000002);
    doReset(1'b0);
    setPhase(`PHASE_PARAM);
    op(OP_READ, `ID_POS_TYPE, 32'h0);
    `CHK("saved type", 32'h00000041, rd)
    op(OP_READ, `ID_FEED, 32'h0);
    `CHK("saved feed", 32'h000003e8, rd)
    `CHK("saved active", 1'b1, loadRefQ)
    doReset(1'b1);
    `CHK("flash cleared", 1'b0, flashValidQ)
    setPhase(`PHASE_PARAM);
    op(OP_READ, `ID_POS_TYPE, 32'h0);
    `CHK("type after power-on", 32'h00000002, rd)
    $display("test backup done");
  endtask

  initial
  begin
    #300000;
    errCount++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    doReset(1'b1);
    t_defaults();
    t_type();
    t_apply();
    t_backup();
    results();
  end
endmodule
